// ---- dram_cfg_pkg.sv ----
// Overview of operation
// R1: Mode bit A3 picks sequential or interleaved.
// R2: Bits A0-A1 pick chop, burst or per-command.
// R3: Per-command mode drives chop select with command.
// R4: Sequential reads rotate within the starting half.
// R5: Interleaved beat i reads column start XOR i.
// R6: Chopped reads float outputs for last four slots.
// R7: Writes use fixed order; chop uses bit two.
// R8: Fixed chop pulls write recovery two clocks in.
// R9: CAS read latency whole clocks; total adds latency.
// R10: Controller keeps test mode bit A7 at zero.
// R11: DLL reset bit clears itself after reset.
// R12: After DLL reset wait lock time, CKE high.
// R13: Program write recovery at least ceiling minimum.
// R14: Power-down DLL bit selects slow or fast exit.
// R15: Second register written with bank select 0 high.
// R16: Reserved mode fields always written as zero.
// R17: Device stops DLL across self-refresh automatically.
// R18: Write leveling without output off limits termination.
// R19: Termination used during writes limited to three.
// R20: DLL off disables termination pin and setting.
// R21: Driver impedance from bits A1 and A5.
// R22: Writes need DLL only with write termination.
// R23: Output disable bit disconnects data and strobes.
// R24: First register written with all banks low.
// R25: Mode fields hold until rewritten by command.
package dram_cfg_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  // Software register offsets
  localparam logic [4:0] OFS_MR0_REQ = 5'h00;
  localparam logic [4:0] OFS_MR1_REQ = 5'h04;
  localparam logic [4:0] OFS_CMD     = 5'h08;
  localparam logic [4:0] OFS_STATUS  = 5'h0C;
  localparam logic [4:0] OFS_MR0_SET = 5'h10;
  localparam logic [4:0] OFS_MR1_SET = 5'h14;

  // Command register fields and operations
  localparam int unsigned CMD_COL_LSB  = 3;
  localparam int unsigned CMD_CHOP_BIT = 6;
  localparam logic [2:0] OP_MRS0     = 3'h1;
  localparam logic [2:0] OP_MRS1     = 3'h2;
  localparam logic [2:0] OP_READ     = 3'h3;
  localparam logic [2:0] OP_WRITE    = 3'h4;
  localparam logic [2:0] OP_PD_ENTER = 3'h5;
  localparam logic [2:0] OP_PD_EXIT  = 3'h6;

  // Status bits, reject and illegal are write-one-to-clear
  localparam int unsigned STS_BUSY_BIT    = 0;
  localparam int unsigned STS_DLLWAIT_BIT = 1;
  localparam int unsigned STS_PD_BIT      = 2;
  localparam int unsigned STS_REJECT_BIT  = 3;
  localparam int unsigned STS_ILLEGAL_BIT = 4;
  localparam int unsigned STS_DLLOFF_BIT  = 5;

  // Mode word fields
  localparam int unsigned MR0_WR_LSB      = 9;
  localparam int unsigned MR0_PPD_BIT     = 12;
  localparam int unsigned MR1_DLLOFF_BIT  = 0;
  localparam int unsigned MR1_LEVEL_BIT   = 7;
  localparam int unsigned MR1_QOFF_BIT    = 12;
  localparam logic [12:0] MR0_TEST_MASK   = 13'h0080;
  localparam logic [12:0] MR0_DLLRST_MASK = 13'h0100;
  localparam logic [12:0] MR1_RSVD_MASK   = 13'h0500;
  localparam logic [12:0] MR1_RTT_MASK    = 13'h0244;
  localparam logic [1:0]  BL_FIXED8 = 2'h0;
  localparam logic [1:0]  BL_OTF    = 2'h1;
  localparam logic [1:0]  BL_FIXED4 = 2'h2;
  localparam logic [2:0]  RTT_OFF   = 3'h0;
  localparam logic [2:0]  RTT_DIV4  = 3'h1;
  localparam logic [2:0]  RTT_DIV2  = 3'h2;
  localparam logic [2:0]  RTT_DIV6  = 3'h3;

  // Pin encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [2:0] BA_MR0    = 3'h0;
  localparam logic [2:0] BA_MR1    = 3'h1;
  localparam logic [3:0] PIN_DES   = 4'hF;
  localparam logic [3:0] PIN_MRS   = 4'h0;
  localparam logic [3:0] PIN_READ  = 4'h5;
  localparam logic [3:0] PIN_WRITE = 4'h4;
  localparam logic       CKE_RESET = 1'b1;

  // Timing
  localparam int unsigned MOD_CYC       = 12;
  localparam int unsigned DLL_LOCK_CYC  = 512;
  localparam int unsigned BURST_CYC     = 4;
  localparam int unsigned READ_GAP_CYC  = 4;
  localparam int unsigned PULL_IN_CYC   = 2;
  localparam int unsigned SLOW_EXIT_NS  = 24;
  localparam int unsigned FAST_EXIT_NS  = 6;
  localparam int unsigned WR_TIME_NS    = 15;
  localparam int unsigned SLOW_EXIT_CYC =
    (SLOW_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAST_EXIT_CYC =
    (FAST_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_MIN_CYC    =
    (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Write recovery code to clock cycles
  function automatic logic [4:0] wr_cycles(input logic [2:0] code);
    case (code)
      3'h1: wr_cycles = 5'h05;
      3'h2: wr_cycles = 5'h06;
      3'h3: wr_cycles = 5'h07;
      3'h4: wr_cycles = 5'h08;
      3'h5: wr_cycles = 5'h0A;
      3'h6: wr_cycles = 5'h0C;
      3'h7: wr_cycles = 5'h0E;
      default: wr_cycles = 5'h10;
    endcase
  endfunction

  // Nominal termination code {A9, A6, A2}
  function automatic logic [2:0] rtt_code(input logic [12:0] w);
    rtt_code = {w[9], w[6], w[2]};
  endfunction

endpackage

// ---- dram_dev_model.sv ----
`timescale 1ns/10ps
module dram_dev_model
  import dram_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Command pins
  input  wire logic        i_cke,
  input  wire logic [3:0]  i_cmd,
  input  wire logic [2:0]  i_ba,
  input  wire logic [12:0] i_addr,
  // Seen command
  output logic             o_seen,
  output logic      [18:0] o_word
);
  logic [12:0] mr0_q;
  logic [12:0] mr1_q;
  logic [2:0]  col_q;
  logic        chop_q;
  logic        sel;
  logic [3:0]  cas_lat;
  logic [3:0]  misc;
  assign sel = i_cke && (i_cmd == PIN_MRS);
  always_ff @(posedge i_clk) begin
    o_seen <= i_rst_n && i_cke && !i_cmd[3];
    o_word <= {i_cmd[2:0], i_ba, i_addr};
    if (sel && i_ba == BA_MR0)
      mr0_q <= i_addr & ~MR0_DLLRST_MASK;
    if (sel && i_ba == BA_MR1) mr1_q <= i_addr;
    if (i_cmd == PIN_READ || i_cmd == PIN_WRITE) begin
      col_q  <= i_addr[2:0];
      chop_q <= mr0_q[1:0] == BL_FIXED4 || !i_addr[12];
    end
  end
  // Column of beat b of the last burst
  function automatic logic [2:0] beat_col(input logic [2:0] b);
    if (mr0_q[3]) beat_col = col_q ^ b;
    else beat_col = {col_q[2] ^ b[2], col_q[1:0] + b[1:0]};
  endfunction
  // Decoded fields
  assign cas_lat = {mr0_q[6:4], mr0_q[2]};
  assign misc[0] = chop_q || mr1_q[12];
  assign misc[1] = mr1_q[5] ^ mr1_q[1];
  assign misc[2] = mr0_q[12] && mr0_q[11:9] != 3'h0;
  assign misc[3] = !mr1_q[0] && beat_col(3'h0) == col_q;
endmodule

// ---- dram_mode_ctrl.sv ----
`timescale 1ns/10ps
module dram_mode_ctrl
  import dram_cfg_pkg::*;
#(
  parameter int unsigned TW = 10
) (
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  // Software register port
  input  wire logic [4:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // DRAM command and address pins
  output logic             O_CKE,
  output logic             O_CS_N,
  output logic             O_RAS_N,
  output logic             O_CAS_N,
  output logic             O_WE_N,
  output logic      [2:0]  O_BA,
  output logic      [12:0] O_ADDR,
  output logic             O_ODT
);
  import dram_cfg_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DLL_WAIT,
    ST_PD
  } state_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_MR0_REQ,
    REG_MR1_REQ,
    REG_CMD,
    REG_STATUS,
    REG_MR0_SET,
    REG_MR1_SET
  } reg_t;

  typedef struct packed {
    state_t      state;
    logic [12:0] mr0_req;
    logic [12:0] mr1_req;
    logic [12:0] mr0_set;
    logic [12:0] mr1_set;
    logic [3:0]  pins;
    logic [2:0]  ba;
    logic [12:0] addr;
    logic        cke;
    logic        odt;
    logic [31:0] rdata;
    logic        reject;
    logic        illegal;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    state:   ST_IDLE,
    pins:    PIN_DES,
    cke:     CKE_RESET,
    default: '0
  };

  if (TW < 2 || TW > 16 || DLL_LOCK_CYC >= (1 << TW)) begin : g_chk
    $error("dram_mode_ctrl timer width too small");
  end

  // Every other wait must fit the timer as well
  if (MOD_CYC >= (1 << TW) || READ_GAP_CYC >= (1 << TW) ||
      SLOW_EXIT_CYC >= (1 << TW) || FAST_EXIT_CYC >= (1 << TW) ||
      BURST_CYC + 16 >= (1 << TW)) begin : g_wait_chk
    $error("dram_mode_ctrl wait longer than timer");
  end

  // Byte address to register, unmapped gives none
  function automatic reg_t reg_decode(input logic [4:0] a);
    if (a == OFS_MR0_REQ) begin
      reg_decode = REG_MR0_REQ;
    end else if (a == OFS_MR1_REQ) begin
      reg_decode = REG_MR1_REQ;
    end else if (a == OFS_CMD) begin
      reg_decode = REG_CMD;
    end else if (a == OFS_STATUS) begin
      reg_decode = REG_STATUS;
    end else if (a == OFS_MR0_SET) begin
      reg_decode = REG_MR0_SET;
    end else if (a == OFS_MR1_SET) begin
      reg_decode = REG_MR1_SET;
    end else begin
      reg_decode = REG_NONE;
    end
  endfunction

  // Power-down exit wait, slow exit when the DLL was frozen; both round to one clock
  function automatic logic [TW-1:0] exit_wait(input logic dll_kept);
    if (dll_kept) begin
      exit_wait = TW'(FAST_EXIT_CYC); // [R14]
    end else begin
      exit_wait = TW'(SLOW_EXIT_CYC); // [R14]
    end
  endfunction

  ctl_t          s_q;
  ctl_t          s_d;
  logic          tmr_load;
  logic [TW-1:0] tmr_count;
  logic          tmr_done;
  logic [12:0]   mr0_word;
  logic [12:0]   mr1_word;
  logic          mr0_ok;
  logic          mr1_ok;
  logic          cmd_take;
  logic [2:0]    op;
  logic [2:0]    col;
  logic          chop;
  logic          clr_reject;
  logic          clr_illegal;
  logic          set_reject;
  logic          set_illegal;
  logic          odt_wanted;
  logic [5:0]    status;
  logic [5:0]    write_gap;
  logic [12:0]   rw_addr;
  reg_t          sel;

  mode_word_check u_check (
    .i_mr0_req  (s_q.mr0_req),
    .i_mr1_req  (s_q.mr1_req),
    .o_mr0_word (mr0_word),
    .o_mr1_word (mr1_word),
    .o_mr0_ok   (mr0_ok),
    .o_mr1_ok   (mr1_ok)
  );

  wait_timer #(
    .W (TW)
  ) u_timer (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RESET_N),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .o_done  (tmr_done)
  );

  always_comb begin
    s_d         = s_q;
    tmr_load    = 1'b0;
    tmr_count   = '0;
    set_reject  = 1'b0;
    set_illegal = 1'b0;

    // Software port decode
    // Register that the address selects
    sel         = reg_decode(I_ADDR);
    cmd_take    = I_WR && (sel == REG_CMD);
    op          = I_WDATA[2:0];
    col         = I_WDATA[CMD_COL_LSB +: 3];
    chop        = I_WDATA[CMD_CHOP_BIT];
    clr_reject  = I_WR && (sel == REG_STATUS) &&
                  I_WDATA[STS_REJECT_BIT];
    clr_illegal = I_WR && (sel == REG_STATUS) &&
                  I_WDATA[STS_ILLEGAL_BIT];
    if (I_WR) begin
      if (sel == REG_MR0_REQ) begin
        s_d.mr0_req = I_WDATA[12:0];
      end else if (sel == REG_MR1_REQ) begin
        s_d.mr1_req = I_WDATA[12:0];
      end
    end

    // Termination only with the DLL on and a nonzero setting
    odt_wanted = (rtt_code(s_q.mr1_set) != RTT_OFF) &&
                 !s_q.mr1_set[MR1_DLLOFF_BIT]; // [R20] [R19]

    // Column address, chop select on A12 when chosen per command
    rw_addr      = '0;
    rw_addr[2:0] = col;
    if (s_q.mr0_set[1:0] == BL_OTF) begin
      rw_addr[12] = ~chop; // [R3]
    end else begin
      rw_addr[12] = 1'b1;
    end

    // Fixed chop starts write recovery two clocks sooner
    write_gap = 6'(BURST_CYC) +
                6'(wr_cycles(s_q.mr0_set[MR0_WR_LSB +: 3]));
    if (s_q.mr0_set[1:0] == BL_FIXED4) begin
      write_gap = write_gap - 6'(PULL_IN_CYC); // [R8]
    end

    // Pins return to deselect unless a command goes out
    s_d.pins = PIN_DES;
    s_d.ba   = '0;
    s_d.addr = '0;

    case (s_q.state)
      ST_IDLE: begin
        if (cmd_take) begin
          case (op)
            OP_MRS0: begin
              if (mr0_ok) begin
                s_d.pins  = PIN_MRS; // [R24]
                s_d.ba    = BA_MR0; // [R24]
                s_d.addr  = mr0_word; // [R10] [R16]
                // Record mirrors the self-clearing reset bit
                s_d.mr0_set = mr0_word & ~MR0_DLLRST_MASK; // [R11]
                tmr_load  = 1'b1;
                if ((mr0_word & MR0_DLLRST_MASK) != '0) begin
                  tmr_count = TW'(DLL_LOCK_CYC); // [R12]
                  s_d.state = ST_DLL_WAIT;
                end else begin
                  tmr_count = TW'(MOD_CYC);
                  s_d.state = ST_WAIT;
                end
              end else begin
                set_illegal = 1'b1; // [R13]
              end
            end
            OP_MRS1: begin
              if (mr1_ok) begin
                s_d.pins    = PIN_MRS; // [R15]
                s_d.ba      = BA_MR1; // [R15]
                s_d.addr    = mr1_word; // [R16] [R20]
                s_d.mr1_set = mr1_word;
                tmr_load    = 1'b1;
                tmr_count   = TW'(MOD_CYC);
                s_d.state   = ST_WAIT;
              end else begin
                set_illegal = 1'b1; // [R18] [R19]
              end
            end
            OP_READ: begin
              s_d.pins  = PIN_READ;
              s_d.addr  = rw_addr; // [R3]
              tmr_load  = 1'b1;
              tmr_count = TW'(READ_GAP_CYC);
              s_d.state = ST_WAIT;
            end
            OP_WRITE: begin
              s_d.pins  = PIN_WRITE;
              s_d.addr  = rw_addr; // [R3]
              s_d.odt   = odt_wanted; // [R20]
              tmr_load  = 1'b1;
              tmr_count = TW'(write_gap); // [R8]
              s_d.state = ST_WAIT;
            end
            OP_PD_ENTER: begin
              s_d.cke   = 1'b0;
              s_d.state = ST_PD;
            end
            default: begin
              set_reject = 1'b1;
            end
          endcase
        end
      end
      ST_WAIT: begin
        if (cmd_take) begin
          set_reject = 1'b1;
        end
        if (tmr_done) begin
          s_d.odt   = 1'b0;
          s_d.state = ST_IDLE;
        end
      end
      ST_DLL_WAIT: begin
        // CKE stays high and nothing is issued until lock
        s_d.cke = 1'b1; // [R12]
        if (cmd_take) begin
          set_reject = 1'b1; // [R12]
        end
        if (tmr_done) begin
          s_d.state = ST_IDLE;
        end
      end
      ST_PD: begin
        if (cmd_take) begin
          if (op == OP_PD_EXIT) begin
            s_d.cke   = 1'b1;
            tmr_load  = 1'b1;
            tmr_count = exit_wait(s_q.mr0_set[MR0_PPD_BIT]); // [R14]
            s_d.state = ST_WAIT;
          end else begin
            set_reject = 1'b1;
          end
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase

    // Sticky flags, a new event wins over a clear
    s_d.reject  = (s_q.reject & ~clr_reject) | set_reject;
    s_d.illegal = (s_q.illegal & ~clr_illegal) | set_illegal;

    // Status view
    status                  = '0;
    status[STS_BUSY_BIT]    = (s_q.state != ST_IDLE);
    status[STS_DLLWAIT_BIT] = (s_q.state == ST_DLL_WAIT);
    status[STS_PD_BIT]      = (s_q.state == ST_PD);
    status[STS_REJECT_BIT]  = s_q.reject;
    status[STS_ILLEGAL_BIT] = s_q.illegal;
    status[STS_DLLOFF_BIT]  = s_q.mr1_set[MR1_DLLOFF_BIT];

    // Read data one cycle after the strobe, zero otherwise
    s_d.rdata = '0;
    if (I_RD) begin
      if (sel == REG_MR0_REQ) begin
        s_d.rdata = {19'h0_0000, s_q.mr0_req};
      end else if (sel == REG_MR1_REQ) begin
        s_d.rdata = {19'h0_0000, s_q.mr1_req};
      end else if (sel == REG_STATUS) begin
        s_d.rdata = {26'h000_0000, status};
      end else if (sel == REG_MR0_SET) begin
        s_d.rdata = {19'h0_0000, s_q.mr0_set}; // [R25]
      end else if (sel == REG_MR1_SET) begin
        s_d.rdata = {19'h0_0000, s_q.mr1_set}; // [R25]
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      s_q <= CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Pin and data outputs straight from flip-flops
  assign O_RDATA = s_q.rdata;
  assign O_CKE   = s_q.cke;
  assign O_CS_N  = s_q.pins[3];
  assign O_RAS_N = s_q.pins[2];
  assign O_CAS_N = s_q.pins[1];
  assign O_WE_N  = s_q.pins[0];
  assign O_BA    = s_q.ba;
  assign O_ADDR  = s_q.addr;
  assign O_ODT   = s_q.odt;
endmodule

// ---- dram_mode_ctrl_assertions.sv ----
`timescale 1ns/10ps
module dram_mode_ctrl_chk
  import dram_cfg_pkg::*;
#(
  parameter int unsigned TW = 10
) (
  // Clock and reset
  input wire logic        I_MCLK,
  input wire logic        I_RESET_N,
  // DRAM pins
  input wire logic        O_CKE,
  input wire logic        O_CS_N,
  input wire logic        O_RAS_N,
  input wire logic        O_CAS_N,
  input wire logic        O_WE_N,
  input wire logic [2:0]  O_BA,
  input wire logic [12:0] O_ADDR,
  input wire logic        O_ODT
);
  localparam int WR_TAB [8] = '{16, 5, 6, 7, 8, 10, 12, 14};
  typedef struct packed {
    logic [12:0] mr0;
    logic        rtt_on;
    logic        dll_off;
    logic [9:0]  lock;
    logic [4:0]  wgap;
  } chk_st_t;
  chk_st_t    st_q;
  chk_st_t    st_d;
  logic [3:0] pins;
  logic       mrs0;
  logic       mrs1;
  assign pins = {O_CS_N, O_RAS_N, O_CAS_N, O_WE_N};
  assign mrs0 = pins == PIN_MRS && O_BA == BA_MR0;
  assign mrs1 = pins == PIN_MRS && O_BA == BA_MR1;
  always_comb begin
    st_d = st_q;
    if (st_q.lock != 10'h000) st_d.lock = st_q.lock - 10'h001;
    if (st_q.wgap != 5'h00) st_d.wgap = st_q.wgap - 5'h01;
    if (mrs0) st_d.mr0 = O_ADDR;
    if (mrs0 && O_ADDR[8]) st_d.lock = 10'(DLL_LOCK_CYC);
    if (mrs1) st_d.dll_off = O_ADDR[0];
    if (mrs1) st_d.rtt_on = !O_ADDR[0] && (O_ADDR & MR1_RTT_MASK) != 0;
    if (pins == PIN_WRITE) st_d.wgap = 5'(WR_TAB[st_q.mr0[11:9]] + 3
      - ((st_q.mr0[1:0] == BL_FIXED4) ? 2 : 0));
  end
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) st_q <= '0;
    else st_q <= st_d;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_mrs0; mrs0; endsequence
  sequence s_mrs1; mrs1; endsequence
  sequence s_rdwr; pins == PIN_READ || pins == PIN_WRITE; endsequence
  sequence s_pd_exit; !O_CKE ##1 O_CKE; endsequence
  chk_test_bit_low: assert property (s_mrs0 |-> !O_ADDR[7])
    else $error("mr0 test bit sent");
  chk_rsvd_zero: assert property (
    s_mrs1 |-> !O_ADDR[8] && !O_ADDR[10])
    else $error("mr1 reserved bit sent");
  chk_rtt_legal: assert property (
    s_mrs1 |-> !O_ADDR[9] || (O_ADDR[7] && O_ADDR[12]))
    else $error("termination code illegal");
  chk_dlloff_rtt: assert property (
    s_mrs1 ##0 O_ADDR[0] |-> (O_ADDR & MR1_RTT_MASK) == 13'h0000)
    else $error("termination with dll off");
  chk_dlloff_odt: assert property (st_q.dll_off |-> !O_ODT)
    else $error("odt with dll off");
  chk_dll_lock: assert property (
    st_q.lock != 0 |-> O_CKE && pins != PIN_READ)
    else $error("dll lock wait broken");
  chk_mrs_bank: assert property (
    pins == PIN_MRS |-> O_BA == BA_MR0 || O_BA == BA_MR1)
    else $error("mrs bank wrong");
  chk_fixed_chop: assert property (
    s_rdwr ##0 st_q.mr0[1:0] != BL_OTF |-> O_ADDR[12])
    else $error("chop pin in fixed mode");
  chk_write_gap: assert property (
    st_q.wgap != 0 |-> O_CS_N && O_ODT == st_q.rtt_on)
    else $error("write recovery gap");
  chk_pd_exit: assert property (s_pd_exit |-> O_CS_N)
    else $error("command at power-down exit");
  chk_pd_quiet: assert property (!O_CKE |-> pins == PIN_DES)
    else $error("command in power-down");
endmodule
bind dram_mode_ctrl dram_mode_ctrl_chk #(.TW(TW)) chk_u (
  .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .O_CKE(O_CKE),
  .O_CS_N(O_CS_N), .O_RAS_N(O_RAS_N), .O_CAS_N(O_CAS_N),
  .O_WE_N(O_WE_N), .O_BA(O_BA), .O_ADDR(O_ADDR), .O_ODT(O_ODT)
);

// ---- mode_word_check.sv ----
`timescale 1ns/10ps
module mode_word_check (
  // Requested words
  input  wire logic [12:0] i_mr0_req,
  input  wire logic [12:0] i_mr1_req,
  // Words to send and legality
  output logic      [12:0] o_mr0_word,
  output logic      [12:0] o_mr1_word,
  output logic             o_mr0_ok,
  output logic             o_mr1_ok
);
  import dram_cfg_pkg::*;

  logic [2:0] rtt;
  logic       dll_off;
  logic       lvl_qoff;

  always_comb begin
    // Test mode never reaches the device
    o_mr0_word = i_mr0_req & ~MR0_TEST_MASK; // [R10]
    o_mr0_ok   = wr_cycles(i_mr0_req[MR0_WR_LSB +: 3])
                 >= 5'(WR_MIN_CYC); // [R13]
    dll_off    = i_mr1_req[MR1_DLLOFF_BIT];
    lvl_qoff   = i_mr1_req[MR1_LEVEL_BIT] & i_mr1_req[MR1_QOFF_BIT];
    o_mr1_word = i_mr1_req & ~MR1_RSVD_MASK; // [R16]
    if (dll_off) begin
      o_mr1_word = o_mr1_word & ~MR1_RTT_MASK; // [R20]
    end
    rtt        = rtt_code(o_mr1_word);
    // Only three strengths unless leveling with outputs off
    o_mr1_ok   = (rtt == RTT_OFF) || (rtt == RTT_DIV2) ||
                 (rtt == RTT_DIV4) || (rtt == RTT_DIV6) ||
                 lvl_qoff; // [R18] [R19]
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import dram_cfg_pkg::*;
  localparam int WR_TAB [8] = '{16, 5, 6, 7, 8, 10, 12, 14};
  logic        I_MCLK = 1'b0;
  logic        I_RESET_N = 1'b0;
  logic [4:0]  I_ADDR = 5'h00;
  logic [31:0] I_WDATA = 32'h0000_0000;
  logic        I_WR = 1'b0;
  logic        I_RD = 1'b0;
  logic [31:0] O_RDATA;
  logic        O_CKE, O_CS_N, O_RAS_N, O_CAS_N, O_WE_N, O_ODT;
  logic [2:0]  O_BA;
  logic [12:0] O_ADDR;
  logic        seen;
  logic [18:0] word;
  logic        rd_seen = 1'b0;
  logic [31:0] rd_q [$];
  logic [18:0] pin_q [$];
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n;
  integer      seed = 32'hae5a;
  logic [31:0] r;
  logic [12:0] m0, m0s, m1;
  logic [1:0]  bl;
  dram_mode_ctrl dut_u (
    .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_CKE(O_CKE), .O_CS_N(O_CS_N), .O_RAS_N(O_RAS_N), .O_CAS_N(O_CAS_N),
    .O_WE_N(O_WE_N), .O_BA(O_BA), .O_ADDR(O_ADDR), .O_ODT(O_ODT)
  );
  dram_dev_model dev_u (
    .i_clk(I_MCLK), .i_rst_n(I_RESET_N), .i_cke(O_CKE),
    .i_cmd({O_CS_N, O_RAS_N, O_CAS_N, O_WE_N}), .i_ba(O_BA),
    .i_addr(O_ADDR), .o_seen(seen), .o_word(word)
  );
  initial forever #50 I_MCLK = ~I_MCLK;
  task automatic stop_test;
    miscompares += rd_q.size() + pin_q.size();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] a);
    samples_checked++;
    if (a !== e) begin
      miscompares++;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge I_MCLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge I_MCLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
  endtask
  task automatic go(input logic [2:0] op, input logic [2:0] col,
                    input logic ch, input logic [15:0] e, input bit has,
                    input int m);
    logic [2:0] p;
    p = (op == OP_READ) ? PIN_READ[2:0] :
        (op == OP_WRITE) ? PIN_WRITE[2:0] : PIN_MRS[2:0];
    if (has) pin_q.push_back({p, e});
    wr(OFS_CMD, {25'h000_0000, ch, col, op});
    repeat (m) @(posedge I_MCLK);
  endtask
  always @(posedge I_MCLK) begin
    rd_seen <= I_RD;
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  always @(negedge I_MCLK) begin
    if (rd_seen) cmp(rd_q.size() ? rd_q.pop_front() : 32'hDEAD_BEEF, O_RDATA);
    if (seen === 1'b1)
      cmp(pin_q.size() ? {13'h0000, pin_q.pop_front()} : 32'hFFFF_FFFF,
          {13'h0000, word});
  end
  initial begin
    repeat (20) @(posedge I_MCLK);
    I_RESET_N <= 1'b1;
    rd(OFS_STATUS, 32'h0000_0000);
    rd(5'h1C, 32'h0000_0000);
    rd(OFS_MR1_SET, 32'h0000_0000);
    wr(OFS_MR1_REQ, 32'h0000_0200);
    go(OP_MRS1, 3'h0, 1'b0, 16'h0000, 1'b0, 2);
    go(OP_PD_EXIT, 3'h0, 1'b0, 16'h0000, 1'b0, 0);
    rd(OFS_STATUS, 32'h0000_0018);
    wr(OFS_STATUS, 32'h0000_0018);
    wr(OFS_MR1_REQ, 32'h0000_1280);
    go(OP_MRS1, 3'h0, 1'b0, {BA_MR1, 13'h1280}, 1'b1, MOD_CYC);
    r = $random(seed);
    m1 = 13'h0540 | (r[12:0] & 13'h0022);
    wr(OFS_MR1_REQ, {19'h0_0000, m1});
    go(OP_MRS1, 3'h0, 1'b0, {BA_MR1, m1 & ~MR1_RSVD_MASK}, 1'b1,
       MOD_CYC);
    rd(OFS_MR1_SET, {19'h0_0000, m1 & ~MR1_RSVD_MASK});
    for (int i = 0; i < 3; i++) begin
      bl = (i == 0) ? BL_FIXED8 : (i == 1) ? BL_OTF : BL_FIXED4;
      r = $random(seed);
      m0 = {r[12:9], 2'b01, r[6:2], bl};
      m0s = m0 & ~MR0_TEST_MASK;
      wr(OFS_MR0_REQ, {19'h0_0000, m0});
      rd(OFS_MR0_REQ, {19'h0_0000, m0});
      go(OP_MRS0, 3'h0, 1'b0, {BA_MR0, m0s}, 1'b1, MOD_CYC);
      rd(OFS_MR0_SET, {19'h0_0000, m0s});
      n = 4 + WR_TAB[m0[11:9]] - ((bl == BL_FIXED4) ? 2 : 0);
      go(OP_WRITE, r[15:13], r[16], {3'h0, (bl != BL_OTF) | ~r[16], 9'h000,
         r[15:13]}, 1'b1, n - 2);
      go(OP_READ, 3'h0, 1'b0, 16'h0000, 1'b0, 0);
      rd(OFS_STATUS, 32'h0000_0008);
      wr(OFS_STATUS, 32'h0000_0008);
      go(OP_READ, r[19:17], r[20], {3'h0, (bl != BL_OTF) | ~r[20], 9'h000,
         r[19:17]}, 1'b1, BURST_CYC);
    end
    wr(OFS_MR1_REQ, 32'h0000_0045);
    go(OP_MRS1, 3'h0, 1'b0, {BA_MR1, 13'h0001}, 1'b1, MOD_CYC);
    rd(OFS_STATUS, 32'h0000_0020);
    go(OP_WRITE, 3'h5, 1'b0, 16'h1005, 1'b1, 20);
    wr(OFS_MR0_REQ, {19'h0_0000, m0 | MR0_DLLRST_MASK});
    go(OP_MRS0, 3'h0, 1'b0, {BA_MR0, m0s | MR0_DLLRST_MASK}, 1'b1,
       0);
    rd(OFS_STATUS, 32'h0000_0023);
    go(OP_READ, 3'h0, 1'b0, 16'h0000, 1'b0, DLL_LOCK_CYC);
    rd(OFS_MR0_SET, {19'h0_0000, m0s});
    rd(OFS_STATUS, 32'h0000_0028);
    wr(OFS_STATUS, 32'h0000_0008);
    go(OP_PD_ENTER, 3'h0, 1'b0, 16'h0000, 1'b0, 4);
    go(OP_READ, 3'h0, 1'b0, 16'h0000, 1'b0, 2);
    go(OP_PD_EXIT, 3'h0, 1'b0, 16'h0000, 1'b0, 4);
    rd(OFS_STATUS, 32'h0000_0028);
    repeat (2) @(posedge I_MCLK);
    stop_test();
  end
endmodule

// ---- wait_timer.sv ----
`timescale 1ns/10ps
module wait_timer #(
  parameter int unsigned W = 10
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Load and status
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_t;

  tmr_t s_q;
  tmr_t s_d;

  if (W < 2 || W > 16) begin : g_chk
    $error("wait_timer width out of range");
  end

  always_comb begin
    s_d = s_q;
    if (i_load) begin
      s_d.cnt = i_count;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_done = (s_q.cnt == '0);
endmodule
